/* File: rtl/ssw_pkg.sv */
/*
 * Shared constants and carrier types for the switch status response
 * word block: register offsets, field positions, reset values and the
 * packed layout of the 16-bit serial response.
 * Assumes a 32-bit APB register bus and a byte-addressed map.
 */
package ssw_pkg;

   // ***********************************************************
   // register map (byte offsets)
   // ***********************************************************
   localparam logic [7:0] ADDR_MODE   = 8'h00; // operating mode code
   localparam logic [7:0] ADDR_ENABLE = 8'h04; // input enables
   localparam logic [7:0] ADDR_METAL  = 8'h08; // wetting pulse select
   localparam logic [7:0] ADDR_STATUS = 8'h0C; // sticky events
   localparam logic [7:0] ADDR_MASK   = 8'h10; // event mask
   localparam logic [7:0] ADDR_CMD    = 8'h14; // last serial command
   localparam logic [7:0] ADDR_RESP   = 8'h18; // last response word

   // ***********************************************************
   // operating mode codes
   // ***********************************************************
   localparam logic [1:0] MODE_SLEEP  = 2'h0; // reset / sleep
   localparam logic [1:0] MODE_NORMAL = 2'h1; // normal
   localparam logic [1:0] MODE_POLL   = 2'h2; // polling
   localparam logic [1:0] MODE_TIMER  = 2'h3; // polling + int timer

   // ***********************************************************
   // widths, field positions and reset values
   // ***********************************************************
   localparam int          SW_W       = 12;     // switch inputs
   localparam int          RESP_W     = 16;     // response bits
   localparam int          ST_W       = 3;      // status bits
   localparam int          ST_FRAME   = 0;      // frame ended
   localparam int          ST_CMD     = 1;      // command received
   localparam int          ST_INTR    = 2;      // interrupt raised
   localparam logic [4:0]  BIT_LAST   = 5'h0F;  // last bit index
   localparam logic [11:0] ENABLE_RST = 12'h000; // all tri-state
   localparam logic [11:0] METAL_RST  = 12'h000; // non-metallic
   localparam logic [2:0]  MASK_RST   = 3'h0;   // all masked

   // ***********************************************************
   // carriers
   // ***********************************************************
   typedef struct packed {
      logic [5:0] gnd;  // ground switch flags, msb = input 11
      logic [3:0] prog; // programmable switch flags
      logic [1:0] bat;  // battery switch flags
   } ssw_flags_type;

   typedef struct packed {
      logic [1:0]    mode;  // response bits 16:15
      logic          role;  // response bit 14
      logic          intr;  // response bit 13
      ssw_flags_type flags; // response bits 12:1
   } ssw_resp_type;

endpackage

/* File: rtl/ssw_sync2.sv */
/*
 * Two flip-flop synchroniser for a bus of independent levels.
 * Assumes each bit is a slow level or a clock far slower than clk;
 * bits are not coherent with one another.
 */
`timescale 1ns/100ps
module ssw_sync2 #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q; // first stage, read only by second stage
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // ***********************************************************
   // next values
   // ***********************************************************
   always_comb begin
      meta_d = d;
      q_d    = meta_q;
   end

   // register both stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= meta_d;
         q      <= q_d;
      end
   end

endmodule

/* File: rtl/ssw_resp_top.sv */
/*
 * Switch monitor status response block: builds and shifts out the
 * 16-bit status word, drives the active-low interrupt pin and the
 * per-input current enables, and exposes control over APB.
 * Assumes serial pins and switch inputs are asynchronous to pclk and
 * that the serial clock is far slower than pclk (mode 0 framing).
 */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps

// Overview of operation
// [RULE1] role flag mirrors strap pin level; the code sends 0 in sleep mode instead
// [RULE2] role flag 0 slave, 1 master
// [RULE3] interrupt flag equals inverse of interrupt pin
// [RULE4] bit 13 meaning depends on mode code
// [RULE5] twelve switch flags, 1 means closed
// [RULE6] inputs latched at chip select fall
// [RULE7] tri-stated inputs get no currents
// [RULE8] disabled inputs always report zero
// [RULE9] mode code in top two bits
// [RULE10] host ignores word during sleep exit
// [RULE11] word shifted msb first while selected
module ssw_resp_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_si,
   output logic             spi_so,
   output logic             spi_so_oe,
   input  wire logic        role_strap_flag,
   input  wire logic [11:0] switch_in,
   output logic             int_n,
   output logic      [11:0] wetting_en,
   output logic      [11:0] sustain_en
);

   // ***********************************************************
   // pin synchronisation
   // ***********************************************************
   logic [15:0]           sync_q;     // synchronised pins
   logic                  role_s;     // strap level
   ssw_pkg::ssw_flags_type sw_s;      // switch closed levels
   logic                  sclk_s;     // serial clock
   logic                  cs_n_s;     // chip select
   logic                  si_s;       // serial in

   ssw_sync2 #(.W(16)) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({role_strap_flag, switch_in, spi_sclk, ~spi_cs_n,
               spi_si}),
      .q     (sync_q)
   );

   assign role_s = sync_q[15];
   assign sw_s   = sync_q[14:3];
   assign sclk_s = sync_q[2];
   assign cs_n_s = ~sync_q[1]; // stored inverted: reset reads as idle
   assign si_s   = sync_q[0];

   // ***********************************************************
   // edge detection
   // ***********************************************************
   logic sclk_prev_q, sclk_prev_d; // sclk one cycle back
   logic cs_prev_q, cs_prev_d;     // cs_n one cycle back
   logic cs_fall, cs_rise;         // frame start / end
   logic sclk_rise, sclk_fall;     // bit edges inside a frame

   // delayed copies of the synchronised levels
   always_comb begin
      sclk_prev_d = sclk_s;
      cs_prev_d   = cs_n_s;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_prev_d;
         cs_prev_q   <= cs_prev_d;
      end
   end

   assign cs_fall   = cs_prev_q & ~cs_n_s;
   assign cs_rise   = ~cs_prev_q & cs_n_s;
   assign sclk_rise = ~cs_n_s & ~sclk_prev_q & sclk_s;
   assign sclk_fall = ~cs_n_s & sclk_prev_q & ~sclk_s;

   // ***********************************************************
   // control registers (declared early, used by the serial side)
   // ***********************************************************
   logic [1:0]            mode_q, mode_d;     // operating mode
   logic [11:0]           enable_q, enable_d; // 1 = input enabled
   logic [11:0]           metal_q, metal_d;   // 1 = wetting pulse
   logic [2:0]            mask_q, mask_d;     // event mask
   logic [2:0]            status_q, status_d; // sticky events

   // ***********************************************************
   // serial response and interrupt pin
   // ***********************************************************
   logic [15:0]           shift_q, shift_d;   // outgoing word
   logic                  so_q, so_d;         // serial out bit
   logic                  so_oe_q, so_oe_d;   // serial out drive
   logic [15:0]           rx_q, rx_d;         // incoming bits
   logic [4:0]            cnt_q, cnt_d;       // bits received
   logic [15:0]           cmd_q, cmd_d;       // last full command
   logic [15:0]           word_q, word_d;     // last response
   ssw_pkg::ssw_flags_type snap_q, snap_d;    // latched flags
   logic                  int_n_q, int_n_d;   // interrupt pin
   ssw_pkg::ssw_flags_type live;              // gated inputs
   ssw_pkg::ssw_resp_type resp;               // word being built
   logic                  intr_set;           // new interrupt cause
   logic                  ev_frame, ev_cmd, ev_intr; // events

   // disabled inputs read as open whatever the pin shows
   assign live = sw_s & enable_q; // RULE8 RULE5

   // next state of the serial side
   always_comb begin
      shift_d  = shift_q;
      so_d     = so_q;
      so_oe_d  = so_oe_q;
      rx_d     = rx_q;
      cnt_d    = cnt_q;
      cmd_d    = cmd_q;
      word_d   = word_q;
      snap_d   = snap_q;
      int_n_d  = int_n_q;
      ev_frame = 1'b0;
      ev_cmd   = 1'b0;
      resp     = '0;
      // assemble the word from the current state
      resp.mode = mode_q; // RULE9
      if (mode_q != ssw_pkg::MODE_SLEEP) begin
         resp.role  = role_s; // RULE1 RULE2
         resp.flags = live; // RULE6
         // bit 13 only carries meaning in normal and timer modes
         if (mode_q != ssw_pkg::MODE_POLL) begin
            resp.intr = ~int_n_q; // RULE3 RULE4
         end
      end
      if (cs_fall) begin
         // latch inputs and present the msb at once
         shift_d = resp; // RULE6
         snap_d  = resp.flags;
         word_d  = resp;
         so_d    = resp.mode[1]; // RULE11
         so_oe_d = 1'b1;
         cnt_d   = 5'h00;
      end else if (sclk_fall) begin
         // next bit out, msb first
         shift_d = {shift_q[14:0], 1'b0}; // RULE11
         so_d    = shift_q[14];
      end else if (sclk_rise) begin
         // collect the command bit by bit
         rx_d = {rx_q[14:0], si_s};
         if (cnt_q == ssw_pkg::BIT_LAST) begin
            cmd_d  = {rx_q[14:0], si_s};
            ev_cmd = 1'b1;
            cnt_d  = 5'h00;
         end else begin
            cnt_d = cnt_q + 5'h01;
         end
      end
      if (cs_rise) begin
         // frame end: release the line, host has seen the flag
         so_oe_d  = 1'b0;
         so_d     = 1'b0;
         ev_frame = 1'b1;
         int_n_d  = 1'b1;
      end
      // a new cause wins over the clear at frame end
      if (intr_set) begin
         int_n_d = 1'b0; // RULE3
      end
   end

   // a switch change outside a frame in an interrupt mode
   assign intr_set = cs_n_s & (live != snap_q) &
                     ((mode_q == ssw_pkg::MODE_NORMAL) |
                      (mode_q == ssw_pkg::MODE_TIMER));
   assign ev_intr  = intr_set & int_n_q;

   // register the serial side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_q <= '0;
         so_q    <= 1'b0;
         so_oe_q <= 1'b0;
         rx_q    <= '0;
         cnt_q   <= '0;
         cmd_q   <= '0;
         word_q  <= '0;
         snap_q  <= '0;
         int_n_q <= 1'b1;
      end else begin
         shift_q <= shift_d;
         so_q    <= so_d;
         so_oe_q <= so_oe_d;
         rx_q    <= rx_d;
         cnt_q   <= cnt_d;
         cmd_q   <= cmd_d;
         word_q  <= word_d;
         snap_q  <= snap_d;
         int_n_q <= int_n_d;
      end
   end

   assign spi_so    = so_q;
   assign spi_so_oe = so_oe_q;
   assign int_n     = int_n_q;

   // ***********************************************************
   // apb slave, current enables and interrupt
   // ***********************************************************
   logic [31:0] prdata_q, prdata_d;   // read data
   logic        pready_q, pready_d;   // access phase ready
   logic        pslverr_q, pslverr_d; // unmapped address
   logic        irq_q, irq_d;         // level interrupt
   logic [11:0] wet_q, wet_d;         // wetting enables
   logic [11:0] sus_q, sus_d;         // sustain enables
   logic        setup, access;        // apb phases
   logic        rd_clear;             // status read completes

   assign setup    = psel & ~penable;
   assign access   = psel & penable & pready_q;
   assign rd_clear = access & ~pwrite & ~pslverr_q &
                     (paddr == ssw_pkg::ADDR_STATUS);

   // next values of the bus side
   always_comb begin
      prdata_d  = prdata_q;
      pready_d  = setup;
      pslverr_d = 1'b0;
      mode_d    = mode_q;
      enable_d  = enable_q;
      metal_d   = metal_q;
      mask_d    = mask_q;
      if (setup) begin
         // decode in setup, answer in the first access cycle
         prdata_d = '0;
         unique case (paddr)
            ssw_pkg::ADDR_MODE:   prdata_d[1:0]  = mode_q;
            ssw_pkg::ADDR_ENABLE: prdata_d[11:0] = enable_q;
            ssw_pkg::ADDR_METAL:  prdata_d[11:0] = metal_q;
            ssw_pkg::ADDR_STATUS: prdata_d[2:0]  = status_q;
            ssw_pkg::ADDR_MASK:   prdata_d[2:0]  = mask_q;
            ssw_pkg::ADDR_CMD:    prdata_d[15:0] = cmd_q;
            ssw_pkg::ADDR_RESP:   prdata_d[15:0] = word_q;
            default:              pslverr_d      = 1'b1;
         endcase
      end
      if (access & pwrite & ~pslverr_q) begin
         // writes take effect at the completing edge only
         unique case (paddr)
            ssw_pkg::ADDR_MODE:   mode_d   = pwdata[1:0];
            ssw_pkg::ADDR_ENABLE: enable_d = pwdata[11:0];
            ssw_pkg::ADDR_METAL:  metal_d  = pwdata[11:0];
            ssw_pkg::ADDR_MASK:   mask_d   = pwdata[2:0];
            default:              mask_d   = mask_q;
         endcase
      end
      // read clears only the bits it reported, fresh events survive
      status_d = rd_clear ? (status_q & ~prdata_q[2:0]) : status_q;
      status_d[ssw_pkg::ST_FRAME] = status_d[ssw_pkg::ST_FRAME] |
                                    ev_frame;
      status_d[ssw_pkg::ST_CMD]   = status_d[ssw_pkg::ST_CMD] | ev_cmd;
      status_d[ssw_pkg::ST_INTR]  = status_d[ssw_pkg::ST_INTR] |
                                    ev_intr;
      irq_d = |(status_d & mask_d);
      // no current at all into a tri-stated input, none in sleep
      sus_d = (mode_q == ssw_pkg::MODE_SLEEP) ? 12'h000 :
              enable_q; // RULE7
      wet_d = sus_d & metal_q; // RULE7
   end

   // register the bus side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         mode_q    <= ssw_pkg::MODE_SLEEP;
         enable_q  <= ssw_pkg::ENABLE_RST;
         metal_q   <= ssw_pkg::METAL_RST;
         mask_q    <= ssw_pkg::MASK_RST;
         status_q  <= '0;
         irq_q     <= 1'b0;
         wet_q     <= '0;
         sus_q     <= '0;
      end else begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         mode_q    <= mode_d;
         enable_q  <= enable_d;
         metal_q   <= metal_d;
         mask_q    <= mask_d;
         status_q  <= status_d;
         irq_q     <= irq_d;
         wet_q     <= wet_d;
         sus_q     <= sus_d;
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign irq        = irq_q;
   assign wetting_en = wet_q;
   assign sustain_en = sus_q;

endmodule

/* File: testbench/ssw_resp_asserts.sv */
/*
 * Checker for the switch status response block: serial pin framing,
 * interrupt pin timing and APB handshake.
 * Assumes it is bound to ssw_resp_top and sees only its ports.
 */
`timescale 1ns/100ps
module ssw_resp_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_so,
   input wire logic spi_so_oe,
   input wire logic int_n
);
   // ******************************************************
   // one clock domain, reset disables every check
   // ******************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   so_drive_a: assert property ((!spi_cs_n)[*6] |-> spi_so_oe)
      else $error("serial out not driven during frame");
   so_release_a: assert property
      (spi_cs_n[*6] |-> !spi_so_oe && !spi_so)
      else $error("serial out still driven when deselected");
   so_hold_a: assert property
      ((spi_sclk && !spi_cs_n)[*2] |-> $stable(spi_so))
      else $error("serial out moved while clock high");
   pin_clear_a: assert property ($rose(spi_cs_n) |-> ##[1:6] int_n)
      else $error("interrupt pin not released after frame");
   pin_set_a: assert property ($fell(int_n) |-> $past(spi_cs_n, 3))
      else $error("interrupt pin asserted inside frame");
   ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not a single pulse after setup");
   ready_cause_a: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("slave error without ready");

   // main scenarios reached
   cover property ($fell(int_n));
   cover property ($rose(spi_so_oe));
   cover property (pslverr);
endmodule

/* File: testbench/ssw_host_model.sv */
/*
 * Host model: serial bus master in mode 0, msb first, 160 ns clock.
 * Assumes the bench resolves the serial output line for it.
 */
`timescale 1ns/100ps
module ssw_host_model (
   output logic     sclk,
   output logic     cs_n,
   output logic     si,
   input wire logic so_line
);
   initial begin
      sclk = 1'b0; // clock stands still outside frames
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // ******************************************************
   // one 16-bit exchange; caller may discard the answer
   // ******************************************************
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
      #7 cs_n = 1'b0;
      #200;
      for (int i = 15; i >= 0; i--) begin
         si = cmd[i];
         #80 sclk = 1'b1;
         rsp[i] = so_line;
         #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      si = ~si; // idle data toggles, never a stale level
   endtask
endmodule

/* File: testbench/switch_status_response_word_tb.sv */
/*
 * Self-checking bench for ssw_resp_top: APB register tasks, host model
 * frames in every mode, interrupt and status checks.
 * Assumes ssw_pkg, ssw_resp_top, the host model and checker are present.
 */
`timescale 1ns/100ps
module switch_status_response_word_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, so, so_oe, int_n, sclk, cs_n, si;
   logic        role_strap_flag = 1'b0;
   logic [11:0] switch_in = 12'h000;
   logic [11:0] wetting_en, sustain_en;
   logic [11:0] en = 12'h000; // enables written so far
   logic [11:0] lat = 12'h000; // flags latched at last frame
   logic [31:0] rd;
   logic        er;
   logic [15:0] resp;
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;
   wire         so_line = so_oe ? so : ~so; // released line never stale

   always #10 pclk = ~pclk;

   ssw_resp_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_si(si), .spi_so(so),
      .spi_so_oe(so_oe), .role_strap_flag(role_strap_flag),
      .switch_in(switch_in), .int_n(int_n), .wetting_en(wetting_en),
      .sustain_en(sustain_en));
   ssw_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so_line(so_line));

   // ******************************************************
   // verdict, comparison and bus tasks
   // ******************************************************
   task automatic results;
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // one APB transfer, waits for ready with no assumed latency
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register read", e, rd);
   endtask

   // frame with expected word worked out from mode, strap and switches
   task automatic xf(input logic [1:0] m);
      logic [11:0] f;
      logic        ie;
      f = switch_in & en;
      ie = (m == ssw_pkg::MODE_NORMAL || m == ssw_pkg::MODE_TIMER) &&
           f != lat;
      chk("int_n", 32'(!ie), 32'(int_n));
      host.xfer({4'h5, f}, resp);
      lat = f;
      chk("resp", {16'h0, m, role_strap_flag, ie, f}, 32'(resp));
      repeat (8) @(posedge pclk);
   endtask

   // bounded run
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         results;
      end
   end

   // ******************************************************
   // main sequence
   // ******************************************************
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("reset int_n", 32'h1, 32'(int_n));
      rdchk(ssw_pkg::ADDR_MODE, 32'h0);
      rdchk(ssw_pkg::ADDR_ENABLE, 32'h0);
      rdchk(ssw_pkg::ADDR_MASK, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped err", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
      host.xfer(16'h0000, resp);
      chk("sleep mode", 32'h0, 32'(resp[15:14]));
      en = 12'hA5C;
      apb(1'b1, ssw_pkg::ADDR_ENABLE, 32'(en));
      apb(1'b1, ssw_pkg::ADDR_METAL, 32'h0FFF);
      chk("sleep current", 32'h0, 32'(sustain_en));
      switch_in <= 12'h3F6;
      role_strap_flag <= 1'b1;
      apb(1'b1, ssw_pkg::ADDR_MODE, 32'(ssw_pkg::MODE_NORMAL));
      repeat (8) @(posedge pclk);
      chk("wetting off", 32'h0, 32'(wetting_en & ~en));
      chk("sustain off", 32'h0, 32'(sustain_en & ~en));
      chk("wetting on", 32'(en), 32'(wetting_en));
      chk("sustain on", 32'(en), 32'(sustain_en));
      xf(ssw_pkg::MODE_NORMAL);
      rdchk(ssw_pkg::ADDR_STATUS, 32'h7);
      rdchk(ssw_pkg::ADDR_STATUS, 32'h0);
      rdchk(ssw_pkg::ADDR_CMD, 32'h5254);
      chk("irq masked", 32'h0, 32'(irq));
      role_strap_flag <= 1'b0;
      @(posedge pclk);
      fork
         xf(ssw_pkg::MODE_NORMAL);
         begin
            #700 @(posedge pclk) switch_in <= ~switch_in;
            #1300 @(posedge pclk) switch_in <= ~switch_in;
         end
      join
      apb(1'b1, ssw_pkg::ADDR_MASK, 32'h1);
      apb(1'b1, ssw_pkg::ADDR_MODE, 32'(ssw_pkg::MODE_POLL));
      switch_in <= 12'hFFF;
      repeat (8) @(posedge pclk);
      xf(ssw_pkg::MODE_POLL);
      chk("irq raised", 32'h1, 32'(irq));
      rdchk(ssw_pkg::ADDR_STATUS, 32'h3);
      repeat (3) @(posedge pclk);
      chk("irq cleared", 32'h0, 32'(irq));
      apb(1'b1, ssw_pkg::ADDR_MODE, 32'(ssw_pkg::MODE_TIMER));
      switch_in <= 12'h000;
      repeat (8) @(posedge pclk);
      xf(ssw_pkg::MODE_TIMER);
      results;
   end
endmodule

bind ssw_resp_top ssw_resp_asserts chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_so(spi_so),
   .spi_so_oe(spi_so_oe), .int_n(int_n));
